// *** tmc_pkg.sv ***
/*
 * Shared constants and types of the two-port memory controller.
 * Assumes a 20 MHz controller clock; all counts are derived here.
 */
`default_nettype none
package tmc_pkg;
    // =========================================================
    // Widths
    localparam int TMC_AW      = 18;
    localparam int TMC_DW      = 16;
    localparam int TMC_WW      = 18;
    localparam int TMC_PLO_BIT = 16;
    localparam int TMC_PHI_BIT = 17;
    localparam int TMC_ROW_W   = 5;
    localparam int TMC_SECT_W_STATIC = 10;
    localparam int TMC_SECT_W_DYN    = 12;

    // =========================================================
    // Timing
    localparam int TMC_CLK_NS        = 50;
    localparam int TMC_REF_PERIOD_NS = 1000000;
    localparam int TMC_REF_ROWS      = 32;
    // Longest spacing, rounded down
    localparam int TMC_REF_INT_CYC   = TMC_REF_PERIOD_NS / TMC_REF_ROWS / TMC_CLK_NS;
    localparam int TMC_PRECH_NS      = 100;
    localparam int TMC_PRECH_CYC     = (TMC_PRECH_NS + TMC_CLK_NS - 1) / TMC_CLK_NS;
    localparam int TMC_ACC_NS        = 150;
    localparam int TMC_ACC_CYC       = (TMC_ACC_NS + TMC_CLK_NS - 1) / TMC_CLK_NS;

    // =========================================================
    // Parity control register
    localparam int         TMC_PREG_W      = 3;
    localparam logic [2:0] TMC_PREG_RST    = 3'h0;
    localparam int         TMC_PREG_ERR_EN = 0;
    localparam int         TMC_PREG_ODD    = 1;
    localparam int         TMC_PREG_SEEN   = 2;
    localparam logic [17:0] TMC_PREG_AREA  = 18'h3FF00;

    // =========================================================
    // Cycle types and sequencer states
    typedef enum logic [1:0] {
        TMC_DATI  = 2'h0,
        TMC_DATIP = 2'h1,
        TMC_DATO  = 2'h2,
        TMC_DATOB = 2'h3
    } tmc_cmd_e;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_PRECH  = 5'h02,
        ST_ACCESS = 5'h04,
        ST_DONE   = 5'h08,
        ST_PAUSE  = 5'h10
    } tmc_state_e;
endpackage
`default_nettype wire

// *** tmc_sync3.sv ***
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes inputs are asynchronous to i_clk and held stable while used.
 */
`timescale 1ns/1ns
`default_nettype none
module tmc_sync3 #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_nrst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] q_reg;
    wire  logic [W-1:0] agree = ~(s2_reg ^ s3_reg);

    // =========================================================
    // Stages; a bit moves only once stages two and three agree
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q_reg  <= '0;
        end else begin
            s1_reg <= i_d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg  <= (s2_reg & agree) | (q_reg & ~agree);
        end
    end

    assign o_q = q_reg;
endmodule
`default_nettype wire

// *** tmc_ctrl.sv ***
/*
 * Two-port memory controller: fast port, shared system bus, four matrices.
 * Assumes fast port logic on i_clk; system bus pins asynchronous.
 */
`timescale 1ns/1ns
`default_nettype none
// What this block does
// RULE_01: Arbitrate refresh, fast port and system bus; winner loads address register.
// RULE_02: Port address copied bit for bit, then strobed into selected matrix.
// RULE_03: Write data register is 18 bits: 16 data plus two byte parity bits.
// RULE_04: Fast port data loads directly; system bus data via its interface.
// RULE_05: Read data register captures word, drives both ports together at end.
// RULE_06: Fast port has separate in/out data; system bus data is bidirectional.
// RULE_07: Address fields pick matrix, section, byte lanes and interleaving.
// RULE_08: Writes load address and data, then enable selected section to write.
// RULE_09: Reads only strobe data out; no restore write-back.
// RULE_10: Dynamic arrays get 32 sequential refresh rows every millisecond.
// RULE_11: Each access precharges, except the write after a read-pause.
// RULE_12: Static arrays: no refresh and no precharge.
// RULE_13: Word writes store low byte parity in bit 16, high in 17.
// RULE_14: Byte writes generate parity only for the written byte.
// RULE_15: Fast port reads check parity; errors are signalled to fast port.
// RULE_16: System bus writes can use odd parity; odd data fails read check.
// RULE_17: Three flip-flop parity control register governs parity behaviour.
// RULE_18: Parity register sits at an address derived from base; read/write.
// RULE_19: Parity register reached only by system bus cycles addressed to it.
// RULE_20: When enabled, parity error goes straight to the processor.
// RULE_21: Up to four matrices, all of one technology.
// RULE_22: Read-with-pause is followed by a write to same place unless error.
// RULE_23: Byte writes present the byte on lanes matching the address.
// RULE_24: Processor acknowledges parity error with its own acknowledge.
// RULE_25: One synchronous clock drives everything; reset clears all registers.
module tmc_ctrl
    import tmc_pkg::*;
#(
    parameter bit          DYNAMIC    = 1'b1,
    parameter bit          INTERLEAVE = 1'b0,
    parameter logic [17:0] BASE_ADDR  = 18'h00000
) (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_fp_req,
    input  wire logic [1:0]  i_fp_cmd,
    input  wire logic [17:0] i_fp_addr,
    input  wire logic [15:0] i_fp_wdata,
    output logic      [15:0] o_fp_rdata,
    output logic             o_fp_done,
    output logic             o_fp_perr,
    input  wire logic        i_fp_perr_ack,
    input  wire logic        i_sb_req,
    input  wire logic [1:0]  i_sb_cmd,
    input  wire logic [17:0] i_sb_addr,
    input  wire logic [15:0] i_sb_data,
    output logic      [15:0] o_sb_data,
    output logic             o_sb_data_oe,
    output logic             o_sb_done,
    output logic      [17:0] o_mad,
    output logic      [3:0]  o_msel,
    output logic      [1:0]  o_mbyte,
    output logic      [17:0] o_mwdata,
    output logic             o_mstrobe,
    output logic             o_mwe,
    output logic             o_mrefresh,
    input  wire logic [17:0] i_mrdata
);
    // =========================================================
    // Geometry; one technology per controller, fixed by DYNAMIC
    localparam int SW = DYNAMIC ? TMC_SECT_W_DYN : TMC_SECT_W_STATIC; // RULE_21
    localparam int HB = SW + 3;
    localparam logic [17:0] PREG_ADDR = TMC_PREG_AREA | 18'(BASE_ADDR >> HB); // RULE_18
    localparam logic [2:0] PRE_LAST = 3'(TMC_PRECH_CYC - 1);
    localparam logic [2:0] ACC_LAST = 3'(TMC_ACC_CYC - 1);
    localparam logic [9:0] REF_LAST = 10'(TMC_REF_INT_CYC - 1);

    function automatic logic [3:0] sel_mod(input logic [17:0] a);
        logic [1:0] m;
        m = INTERLEAVE ? a[2:1] : a[SW+2:SW+1];
        sel_mod = 4'h1 << m;
    endfunction

    function automatic logic [1:0] byte_en(input logic [1:0] c, input logic a0);
        byte_en = (c == TMC_DATOB) ? (a0 ? 2'h2 : 2'h1) : 2'h3;
    endfunction

    function automatic logic par(input logic [7:0] b, input logic odd);
        par = (^b) ^ odd;
    endfunction

    // =========================================================
    // Registers
    tmc_state_e  st_reg;
    tmc_state_e  st_next;
    logic [2:0]  cnt_reg;
    logic [17:0] mad_reg;
    logic [3:0]  msel_reg;
    logic [1:0]  mbyte_reg;
    logic [17:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic [1:0]  cmd_reg;
    logic        own_fp_reg;
    logic        own_ref_reg;
    logic        pw_reg;
    logic        odd_reg;
    logic        strobe_reg;
    logic        we_reg;
    logic        refr_reg;
    logic        fp_done_reg;
    logic        fp_perr_reg;
    logic        sb_done_reg;
    logic        sb_oe_reg;
    logic        sb_taken_reg;
    logic [2:0]  preg_reg;
    logic [9:0]  ref_cnt_reg;
    logic        ref_pend_reg;
    logic [4:0]  row_reg;

    // =========================================================
    // System bus pins through the interface synchroniser
    logic [36:0] sb_sync;
    tmc_sync3 #(
        .W (37)
    ) u_sb_sync (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .i_d    ({i_sb_req, i_sb_cmd, i_sb_addr, i_sb_data}),
        .o_q    (sb_sync)
    );
    wire logic        sb_req   = sb_sync[36];
    wire logic [1:0]  sb_cmd   = sb_sync[35:34];
    wire logic [17:0] sb_addr  = sb_sync[33:16];
    wire logic [15:0] sb_wdata = sb_sync[15:0];

    // =========================================================
    // Arbitration: refresh, then fast port, then system bus
    wire logic in_idle  = st_reg == ST_IDLE;
    wire logic in_pause = st_reg == ST_PAUSE;
    wire logic ref_win  = DYNAMIC && ref_pend_reg; // RULE_12
    wire logic sb_new   = sb_req && !sb_taken_reg;
    wire logic sb_preg  = sb_new && (sb_addr == PREG_ADDR); // RULE_19
    wire logic sb_hit   = sb_new && !sb_preg && (sb_addr[17:HB] == BASE_ADDR[17:HB]);
    wire logic sb_miss  = sb_new && !sb_preg && !sb_hit;
    wire logic start_ref = in_idle && ref_win; // RULE_10
    wire logic start_fp  = i_fp_req && ((in_idle && !ref_win) || (in_pause && own_fp_reg)); // RULE_01
    wire logic start_sb  = sb_hit && ((in_idle && !ref_win && !i_fp_req)
                                      || (in_pause && !own_fp_reg));
    wire logic preg_go   = sb_preg && in_idle && !ref_win && !i_fp_req;
    wire logic start_any = start_ref || start_fp || start_sb;
    // Error during a paused read frees the memory; the write need not come
    wire logic pause_quit = in_pause && own_fp_reg && fp_perr_reg && !i_fp_req; // RULE_22

    // =========================================================
    // Values loaded at the start of a cycle
    wire logic [1:0]  st_cmd  = start_fp ? i_fp_cmd : sb_cmd;
    wire logic [17:0] st_addr = start_fp ? i_fp_addr : sb_addr; // RULE_02
    wire logic        st_wr   = !start_ref && st_cmd[1];
    wire logic        st_pw   = in_pause && st_wr; // RULE_11
    // Fast data straight in; system data from its interface stage
    wire logic [15:0] st_data = start_fp ? i_fp_wdata : sb_wdata; // RULE_04
    wire logic        st_odd  = !start_fp && preg_reg[TMC_PREG_ODD]; // RULE_16
    wire logic [1:0]  st_be   = byte_en(st_cmd, st_addr[0]); // RULE_07 RULE_23
    wire logic [17:0] st_wdata = {st_be[1] & par(st_data[15:8], st_odd), // RULE_14
                                  st_be[0] & par(st_data[7:0], st_odd), // RULE_13
                                  st_data}; // RULE_03

    // =========================================================
    // Sequencer
    wire logic cnt_done = (st_reg == ST_PRECH && cnt_reg == PRE_LAST)
                       || (st_reg == ST_ACCESS && cnt_reg == ACC_LAST);
    wire logic end_acc  = st_reg == ST_ACCESS && cnt_reg == ACC_LAST;
    wire logic cap      = end_acc && !cmd_reg[1] && !own_ref_reg;
    wire logic chk_err  = (^i_mrdata[7:0] ^ i_mrdata[TMC_PLO_BIT])
                       | (^i_mrdata[15:8] ^ i_mrdata[TMC_PHI_BIT]);
    wire logic perr_hit = cap && own_fp_reg && chk_err; // RULE_15
    wire logic ref_nxt  = start_any ? start_ref : own_ref_reg;
    wire logic wr_nxt   = start_any ? st_wr : cmd_reg[1] && !own_ref_reg;

    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            ST_IDLE, ST_PAUSE: begin
                if (start_any) begin
                    st_next = (DYNAMIC && !st_pw) ? ST_PRECH : ST_ACCESS; // RULE_11 RULE_12
                end else if (pause_quit) begin
                    st_next = ST_IDLE;
                end
            end
            ST_PRECH: begin
                if (cnt_done) begin
                    st_next = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (cnt_done) begin
                    st_next = ST_DONE;
                end
            end
            ST_DONE: begin
                st_next = (cmd_reg == TMC_DATIP && !own_ref_reg) ? ST_PAUSE : ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin // RULE_25
        if (!i_nrst) begin
            st_reg  <= ST_IDLE;
            cnt_reg <= 3'h0;
        end else begin
            st_reg  <= st_next;
            cnt_reg <= (st_next != st_reg) ? 3'h0 : cnt_reg + 3'h1;
        end
    end

    // =========================================================
    // Address, data and strobe registers toward the matrices
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mad_reg     <= 18'h00000;
            msel_reg    <= 4'h0;
            mbyte_reg   <= 2'h0;
            wdata_reg   <= 18'h00000;
            cmd_reg     <= 2'h0;
            own_fp_reg  <= 1'b0;
            own_ref_reg <= 1'b0;
            pw_reg      <= 1'b0;
            odd_reg     <= 1'b0;
        end else if (start_ref) begin
            mad_reg     <= {13'h0000, row_reg}; // RULE_10
            msel_reg    <= 4'hF;
            mbyte_reg   <= 2'h0;
            cmd_reg     <= TMC_DATI;
            own_fp_reg  <= 1'b0;
            own_ref_reg <= 1'b1;
            pw_reg      <= 1'b0;
        end else if (start_any) begin
            mad_reg     <= st_addr; // RULE_01 RULE_02
            msel_reg    <= sel_mod(st_addr); // RULE_07
            mbyte_reg   <= st_be;
            wdata_reg   <= st_wdata; // RULE_08
            cmd_reg     <= st_cmd;
            own_fp_reg  <= start_fp;
            own_ref_reg <= 1'b0;
            pw_reg      <= st_pw;
            odd_reg     <= st_odd;
        end
    end

    // Strobes are decoded from the next state so they leave flip-flops
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            strobe_reg <= 1'b0;
            we_reg     <= 1'b0;
            refr_reg   <= 1'b0;
        end else begin
            strobe_reg <= st_next == ST_ACCESS; // RULE_02
            we_reg     <= st_next == ST_ACCESS && wr_nxt; // RULE_08 RULE_09
            refr_reg   <= (st_next == ST_ACCESS || st_next == ST_PRECH) && ref_nxt;
        end
    end

    // =========================================================
    // Read data and port answers
    wire logic sb_rd_end = end_acc && !own_fp_reg && !own_ref_reg && !cmd_reg[1];
    wire logic sb_end    = (end_acc && !own_fp_reg && !own_ref_reg) || preg_go;
    wire logic preg_wr   = preg_go && sb_cmd[1];

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_reg <= 16'h0000;
        end else if (cap) begin
            rdata_reg <= i_mrdata[15:0]; // RULE_05 RULE_09
        end else if (preg_go && !sb_cmd[1]) begin
            rdata_reg <= {13'h0000, preg_reg}; // RULE_18
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            fp_done_reg  <= 1'b0;
            sb_done_reg  <= 1'b0;
            sb_oe_reg    <= 1'b0;
            sb_taken_reg <= 1'b0;
        end else begin
            fp_done_reg  <= end_acc && own_fp_reg; // RULE_05
            sb_done_reg  <= sb_end || (sb_done_reg && sb_req);
            // Drive the shared lines only for a read answer
            sb_oe_reg    <= sb_rd_end || (preg_go && !sb_cmd[1])
                            || (sb_oe_reg && sb_req); // RULE_06
            sb_taken_reg <= start_sb || preg_go || sb_miss || (sb_taken_reg && sb_req);
        end
    end

    // =========================================================
    // Parity control register and error flag; set beats clear
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            preg_reg    <= TMC_PREG_RST; // RULE_17
            fp_perr_reg <= 1'b0;
        end else begin
            preg_reg[TMC_PREG_ERR_EN] <= preg_wr ? sb_wdata[TMC_PREG_ERR_EN]
                                                 : preg_reg[TMC_PREG_ERR_EN];
            preg_reg[TMC_PREG_ODD]    <= preg_wr ? sb_wdata[TMC_PREG_ODD]
                                                 : preg_reg[TMC_PREG_ODD];
            preg_reg[TMC_PREG_SEEN]   <= perr_hit || (preg_wr ? sb_wdata[TMC_PREG_SEEN]
                                                              : preg_reg[TMC_PREG_SEEN]);
            fp_perr_reg <= (perr_hit && preg_reg[TMC_PREG_ERR_EN])
                           || (fp_perr_reg && !i_fp_perr_ack); // RULE_20 RULE_24
        end
    end

    // =========================================================
    // Refresh timer: one row per interval, 32 rows per period
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ref_cnt_reg  <= 10'h000;
            ref_pend_reg <= 1'b0;
            row_reg      <= 5'h00;
        end else if (DYNAMIC) begin
            ref_cnt_reg  <= (ref_cnt_reg == REF_LAST) ? 10'h000 : ref_cnt_reg + 10'h001;
            ref_pend_reg <= (ref_cnt_reg == REF_LAST) || (ref_pend_reg && !start_ref);
            row_reg      <= start_ref ? row_reg + 5'h01 : row_reg; // RULE_10
        end
    end

    assign o_mad        = mad_reg;
    assign o_msel       = msel_reg;
    assign o_mbyte      = mbyte_reg;
    assign o_mwdata     = wdata_reg;
    assign o_mstrobe    = strobe_reg;
    assign o_mwe        = we_reg;
    assign o_mrefresh   = refr_reg;
    assign o_fp_rdata   = rdata_reg;
    assign o_sb_data    = rdata_reg;
    assign o_fp_done    = fp_done_reg;
    assign o_fp_perr    = fp_perr_reg;
    assign o_sb_done    = sb_done_reg;
    assign o_sb_data_oe = sb_oe_reg;

    // =========================================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_prech_wait;
        (st_reg == ST_PRECH && !o_mwe)[*2];
    endsequence
    sequence s_write_pulse;
        (o_mwe && o_mstrobe)[*3];
    endsequence

    property p_static_no_ref;
        !DYNAMIC |-> (!o_mrefresh && st_reg != ST_PRECH);
    endproperty
    a_static_no_ref: assert property (p_static_no_ref) else $error("refresh or precharge on static"); // RULE_12

    property p_prech;
        $rose(o_mstrobe) && !pw_reg && DYNAMIC |-> $past(st_reg == ST_PRECH);
    endproperty
    a_prech: assert property (p_prech) else $error("access without precharge"); // RULE_11

    property p_pw_skip;
        $rose(o_mstrobe) && pw_reg |-> $past(st_reg == ST_PAUSE);
    endproperty
    a_pw_skip: assert property (p_pw_skip) else $error("paused write was precharged"); // RULE_11

    property p_ref_first;
        start_ref |=> (o_mrefresh && o_msel == 4'hF && !o_mwe);
    endproperty
    a_ref_first: assert property (p_ref_first) else $error("refresh did not win"); // RULE_01

    property p_wr_seq;
        start_any && st_wr && !st_pw && DYNAMIC |=> s_prech_wait ##1 s_write_pulse;
    endproperty
    a_wr_seq: assert property (p_wr_seq) else $error("write strobe sequence wrong"); // RULE_08

    property p_par_lo;
        o_mwe && o_mbyte[0] |-> o_mwdata[TMC_PLO_BIT] == (^o_mwdata[7:0] ^ odd_reg);
    endproperty
    a_par_lo: assert property (p_par_lo) else $error("low byte parity wrong"); // RULE_13

    property p_par_byte;
        o_mwe && o_mbyte == 2'h2
            |-> !o_mwdata[TMC_PLO_BIT] && o_mwdata[TMC_PHI_BIT] == (^o_mwdata[15:8] ^ odd_reg);
    endproperty
    a_par_byte: assert property (p_par_byte) else $error("byte write parity wrong"); // RULE_14

    property p_perr;
        perr_hit && preg_reg[TMC_PREG_ERR_EN] |=> o_fp_perr && o_fp_done;
    endproperty
    a_perr: assert property (p_perr) else $error("parity error not reported"); // RULE_15

    property p_rd_both;
        cap && own_fp_reg |=> o_fp_done && o_fp_rdata == $past(i_mrdata[15:0]);
    endproperty
    a_rd_both: assert property (p_rd_both) else $error("read data not presented"); // RULE_05

    property p_oe;
        o_sb_data_oe |-> o_sb_done;
    endproperty
    a_oe: assert property (p_oe) else $error("bus driven without answer"); // RULE_06

    property p_read_nowe;
        st_reg == ST_ACCESS && !cmd_reg[1] |-> !o_mwe;
    endproperty
    a_read_nowe: assert property (p_read_nowe) else $error("write strobe on read"); // RULE_09
endmodule
`default_nettype wire

// *** tmc_mat_mdl.sv ***
/* Matrix side model: 256 words of 18 bits behind the controller.
   Assumes byte address bits [8:1] pick the word. */
`timescale 1ns/1ns
`default_nettype none
module tmc_mat_mdl (
    input  wire logic        i_clk,
    input  wire logic [17:0] i_mad,
    input  wire logic [1:0]  i_mbyte,
    input  wire logic [17:0] i_mwdata,
    input  wire logic        i_mstrobe,
    input  wire logic        i_mwe,
    output logic      [17:0] o_mrdata
);
    logic [17:0] mem [0:255];
    wire  [17:0] lane = {i_mbyte, {8{i_mbyte[1]}}, {8{i_mbyte[0]}}};
    // ==========================================
    // Storage
    always @(posedge i_clk) begin
        if (i_mstrobe && i_mwe) begin
            mem[i_mad[8:1]] <= (mem[i_mad[8:1]] & ~lane) | (i_mwdata & lane);
        end
        // Idle lines toggle so stale data is never mistaken for a read
        o_mrdata <= (i_mstrobe && !i_mwe) ? mem[i_mad[8:1]] : ~o_mrdata;
    end
endmodule
`default_nettype wire

// *** tb_top.sv ***
/* Self-checking bench for tmc_ctrl, matrix model on the memory side.
   Assumes default parameters: dynamic, base 0, byte addresses below 512. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import tmc_pkg::*;
    logic        i_clk = 0, i_nrst = 0, i_fp_req = 0, i_fp_perr_ack = 0, i_sb_req = 0;
    logic [1:0]  i_fp_cmd = 0, i_sb_cmd = 0, o_mbyte, c;
    logic [17:0] i_fp_addr = 0, i_sb_addr = 0, o_mad, o_mwdata, i_mrdata, a;
    logic [15:0] i_fp_wdata = 0, i_sb_data = 0, o_fp_rdata, o_sb_data, d, sh [0:255];
    logic        o_fp_done, o_fp_perr, o_sb_data_oe, o_sb_done, o_mstrobe, o_mwe, o_mrefresh;
    logic [3:0]  o_msel;
    logic [4:0]  row;
    logic [16:0] r;
    int          failures = 0, n_tests = 0, seed = 83, cyc = 0, k, t0;
    tmc_ctrl uut (.i_clk, .i_nrst, .i_fp_req, .i_fp_cmd, .i_fp_addr, .i_fp_wdata, .o_fp_rdata,
        .o_fp_done, .o_fp_perr, .i_fp_perr_ack, .i_sb_req, .i_sb_cmd, .i_sb_addr, .i_sb_data,
        .o_sb_data, .o_sb_data_oe, .o_sb_done, .o_mad, .o_msel, .o_mbyte, .o_mwdata,
        .o_mstrobe, .o_mwe, .o_mrefresh, .i_mrdata);
    tmc_mat_mdl mat (.i_clk, .i_mad(o_mad), .i_mbyte(o_mbyte), .i_mwdata(o_mwdata),
        .i_mstrobe(o_mstrobe), .i_mwe(o_mwe), .o_mrdata(i_mrdata));
    // ==========================================
    // Helpers
    always #25 i_clk = ~i_clk;
    // Run needs about 4000 cycles; ceiling leaves ample margin
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            tally_and_finish;
        end
    end
    task automatic tally_and_finish;
        $display("failures %0d n_tests %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    function automatic logic [17:0] wexp(input logic [1:0] cm, input logic hi,
                                         input logic [15:0] w);
        if (cm == TMC_DATO) return {^w[15:8], ^w[7:0], w};
        return hi ? {^w[15:8], 1'b0, w[15:8], 8'h00} : {1'b0, ^w[7:0], 8'h00, w[7:0]};
    endfunction
    task automatic fp(input logic [1:0] cm, input logic [17:0] ad, input logic [15:0] w,
                      input logic ep);
        int t;
        logic ws;
        logic [19:0] cap;
        @(negedge i_clk);
        i_fp_cmd = cm;
        i_fp_addr = ad;
        i_fp_wdata = w;
        i_fp_req = 1'b1;
        t = 0;
        ws = 1'b0;
        do begin
            @(negedge i_clk);
            t++;
            if (o_mwe === 1'b1) ws = 1'b1;
            if (o_mwe === 1'b1) cap = {o_mbyte, o_mwdata};
        end while (o_fp_done !== 1'b1 && t < 40);
        i_fp_req = 1'b0;
        if (t == 40) failures++;
        chk({2'h0, o_mad}, {2'h0, ad});
        chk(20'(o_msel), 20'(4'h1 << ad[14:13]));
        if (cm[1]) begin
            cap[17:0] &= (cm == TMC_DATO) ? 18'h3FFFF : (ad[0] ? 18'h3FF00 : 18'h300FF);
            chk(cap, {cm == TMC_DATO ? 2'h3 : {ad[0], ~ad[0]}, wexp(cm, ad[0], w)});
            if (cm == TMC_DATO) sh[ad[8:1]] = w;
            else if (ad[0]) sh[ad[8:1]][15:8] = w[15:8];
            else sh[ad[8:1]][7:0] = w[7:0];
        end else chk({2'h0, ws, o_fp_perr, o_fp_rdata}, {3'h0, ep, sh[ad[8:1]]});
    endtask
    task automatic sb(input logic [1:0] cm, input logic [17:0] ad, input logic [15:0] w,
                      output logic [16:0] rd);
        int t;
        @(negedge i_clk);
        i_sb_cmd = cm;
        i_sb_addr = ad;
        i_sb_data = w;
        @(negedge i_clk);
        i_sb_req = 1'b1;
        t = 0;
        do begin
            @(negedge i_clk);
            t++;
        end while (o_sb_done !== 1'b1 && t < 60);
        rd = {o_sb_data_oe, o_sb_data};
        i_sb_req = 1'b0;
        if (t == 60) failures++;
        while (o_sb_done !== 1'b0 && t < 90) begin
            @(negedge i_clk);
            t++;
        end
        if (t >= 90) failures++;
    endtask
    // ==========================================
    // Stimulus
    initial begin
        repeat (16) @(negedge i_clk);
        chk(20'({o_fp_done, o_sb_done, o_mstrobe, o_mwe, o_mrefresh}), 20'h0);
        i_nrst = 1'b1;
        for (k = 0; k < 256; k++) fp(TMC_DATO, 18'(k * 2), 16'($random(seed)), 1'b0);
        fp(TMC_DATIP, 18'h00041, 16'h0, 1'b0);
        fp(TMC_DATOB, 18'h00041, 16'hA55A, 1'b0);
        fp(TMC_DATI, 18'h00040, 16'h0, 1'b0);
        repeat (60) begin
            c = 2'($random(seed));
            a = 18'($random(seed)) & 18'h001FF;
            d = 16'($random(seed));
            fp(c, a, d, 1'b0);
            if (c == TMC_DATIP) fp(TMC_DATO, a, ~d, 1'b0);
        end
        sb(TMC_DATO, TMC_PREG_AREA, 16'h0003, r);
        sb(TMC_DATI, TMC_PREG_AREA, 16'h0, r);
        chk(20'(r), 20'h10003);
        sb(TMC_DATO, 18'h00010, 16'h1234, r);
        sb(TMC_DATO, TMC_PREG_AREA, 16'h0001, r);
        sh[8] = 16'h1234;
        fp(TMC_DATI, 18'h00010, 16'h0, 1'b1);
        @(negedge i_clk);
        i_fp_perr_ack = 1'b1;
        @(negedge i_clk);
        i_fp_perr_ack = 1'b0;
        @(negedge i_clk);
        chk(20'(o_fp_perr), 20'h0);
        sb(TMC_DATI, TMC_PREG_AREA, 16'h0, r);
        chk(20'(r), 20'h10005);
        sb(TMC_DATI, 18'h00010, 16'h0, r);
        chk(20'(r), 20'h11234);
        chk(20'(o_fp_rdata), 20'h01234);
        @(negedge i_clk);
        i_sb_addr = 18'h20000;
        i_sb_req = 1'b1;
        repeat (20) @(negedge i_clk);
        chk(20'(o_sb_done), 20'h0);
        i_sb_req = 1'b0;
        repeat (8) @(negedge i_clk);
        k = 0;
        repeat (3) begin
            while (o_mrefresh !== 1'b1) @(negedge i_clk);
            if (k > 0) chk(20'(o_mad[4:0]), 20'(5'(row + 5'h01)));
            if (k == 2) chk(20'(cyc - t0), 20'(TMC_REF_INT_CYC));
            chk(20'(o_msel), 20'h0000F);
            row = o_mad[4:0];
            t0 = cyc;
            k++;
            while (o_mrefresh === 1'b1) @(negedge i_clk);
        end
        tally_and_finish;
    end
endmodule
`default_nettype wire
